// >>> exec_pkg.sv
// Shared constants for the index, status and add execution logic
package exec_pkg;
  localparam int WORD_W = 16;
  localparam int OP_W = 5;
  // Instruction field positions, bit 0 of the word is the least significant
  localparam int OP_HI = 15;
  localparam int OP_LO = 11;
  localparam int FMT_BIT = 10;
  localparam int TAG_HI = 9;
  localparam int TAG_LO = 8;
  localparam int DISP_HI = 7;
  localparam int DISP_SIGN = 7;
  localparam int IND_BIT = 7;
  localparam int PROT_SEL_BIT = 6;
  localparam int PROT_VAL_BIT = 0;
  localparam int LDS_CARRY_BIT = 1;
  localparam int LDS_OVF_BIT = 0;
  // Status word layout when indicators are stored
  localparam int STS_CARRY_BIT = 1;
  localparam int STS_OVF_BIT = 0;
  localparam int STS_KEEP_HI = 15;
  localparam int STS_KEEP_LO = 8;
  // Operation codes, top five bits of the first word
  localparam logic [4:0] OP_LOAD_INDEX = 5'h0C;
  localparam logic [4:0] OP_STORE_INDEX = 5'h0D;
  localparam logic [4:0] OP_STORE_STATUS = 5'h05;
  localparam logic [4:0] OP_LOAD_STATUS = 5'h04;
  localparam logic [4:0] OP_ADD = 5'h10;
  localparam logic [4:0] OP_DOUBLE_ADD = 5'h11;
  localparam logic [4:0] OP_SUBTRACT = 5'h12;
  localparam logic [1:0] TAG_INSTR = 2'h0;
  // Reset values and the double add odd address mask
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic RST_IND = 1'b0;
  localparam logic [15:0] ODD_MASK = 16'h0001;
endpackage

// >>> arith_unit.sv
// Two's complement add and subtract with carry and overflow detection
`timescale 1ns/100ps
module arith_unit (
  input wire logic [31:0] acc_pair,
  input wire logic [31:0] operand,
  input wire logic subtract,
  input wire logic double_len,
  output logic [31:0] result,
  output logic carry_out,
  output logic overflow_out
);
  logic [31:0] x;
  logic [31:0] y;
  logic [32:0] wide;

  // Single length work is aligned to the top so the same carry and sign
  // positions serve both lengths
  always_comb begin
    x = double_len ? acc_pair : {acc_pair[31:16], 16'h0000};
    y = double_len ? operand : {operand[31:16], 16'h0000};
    if (subtract) begin
      wide = {1'b0, x} - {1'b0, y};
    end else begin
      wide = {1'b0, x} + {1'b0, y};
    end
    result = double_len ? wide[31:0] : {wide[31:16], acc_pair[15:0]};
    carry_out = wide[32];
    if (subtract) begin
      overflow_out = (x[31] != y[31]) && (wide[31] != x[31]);
    end else begin
      overflow_out = (x[31] == y[31]) && (wide[31] != x[31]);
    end
  end
endmodule // arith_unit

// >>> index_status_add_execute.sv
// Executes load/store index, status, protect bit, add, double add and subtract
`timescale 1ns/100ps
// Function
// RULE1 - One-word load index puts offset in instruction register for tag 00, else index
// RULE2 - Short offset loaded into a register is sign extended from its sign bit
// RULE3 - Two-word direct load index loads the second word itself
// RULE4 - Two-word indirect load index loads the storage word addressed by second word
// RULE5 - Store index writes instruction register or selected index at operand location
// RULE6 - Store status puts carry in bit 14 and overflow in bit 15
// RULE7 - Store status keeps bits 0-7, zeroes bits 8-13, merging with storage
// RULE8 - Store status clears carry and overflow while storing them
// RULE9 - Store status has one-word, two-word direct and two-word indirect forms
// RULE10 - Protect form sets protect bit when bit 15 is one, clears it otherwise
// RULE11 - Protect bit is changed only while the permission switch enables it
// RULE12 - Protect form is two-word only, selected by bit 9, direct or indirect
// RULE13 - Load status is one-word only, indicators from instruction bits 14 and 15
// RULE14 - Load status codes 2000 to 2003 clear or set the two indicators
// RULE15 - Add puts two's complement sum in accumulator, storage untouched
// RULE16 - Add sets overflow when the sum leaves the 16-bit signed range
// RULE17 - Overflow is sticky; only status instructions or a test clear it
// RULE18 - Add sets carry on carry out of the top accumulator bit
// RULE19 - Double add adds even and next word to accumulator and extension
// RULE20 - Odd double add location adds that same word to both halves
// RULE21 - After double add, carry reflects only this instruction's carry out
// RULE22 - Double add sets sticky overflow when sum leaves 32-bit signed range
// RULE23 - Subtract puts accumulator minus operand in accumulator, storage untouched
// RULE24 - Subtract sets sticky overflow when difference leaves 16-bit signed range
// RULE25 - Subtract sets carry on a borrow out of the top accumulator bit
module index_status_add_execute (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic issue,
  input wire logic [15:0] instr_word,
  input wire logic [15:0] addr_word,
  input wire logic protect_write_sw,
  input wire logic overflow_test_clear,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  output logic busy,
  output logic done,
  output logic illegal,
  output logic mem_req,
  output logic mem_we,
  output logic mem_prot_we,
  output logic [15:0] mem_addr,
  output logic [15:0] mem_wdata,
  output logic mem_prot_wdata,
  output logic [15:0] acc,
  output logic [15:0] acc_ext,
  output logic carry,
  output logic overflow,
  output logic [15:0] instr_reg,
  output logic [15:0] index_register1,
  output logic [15:0] index_register2,
  output logic [15:0] index_register3
);
  typedef enum logic [6:0] {
    S_IDLE  = 7'b0000001,
    S_IND   = 7'b0000010,
    S_EXEC  = 7'b0000100,
    S_OPND  = 7'b0001000,
    S_OPND2 = 7'b0010000,
    S_WRITE = 7'b0100000,
    S_PROT  = 7'b1000000
  } state_e;

  state_e state_ff;
  state_e nxt_state;
  logic [15:0] ir_ff;
  logic [15:0] ea_ff;
  logic [15:0] nxt_ea;
  logic [15:0] hi_word_ff;
  logic [15:0] acc_ff;
  logic [15:0] ext_ff;
  logic carry_ff;
  logic ovf_ff;
  logic [15:0] i_ff;
  logic [15:0] xr1_ff;
  logic [15:0] xr2_ff;
  logic [15:0] xr3_ff;
  logic sw_meta_ff;
  logic sw_sync_ff;
  logic mem_req_ff;
  logic mem_we_ff;
  logic mem_prot_we_ff;
  logic [15:0] mem_addr_ff;
  logic [15:0] mem_wdata_ff;
  logic mem_prot_wdata_ff;
  logic [15:0] nxt_addr;
  logic [15:0] nxt_wdata;
  logic nxt_we;
  logic nxt_prot_we;
  logic done_ff;
  logic busy_ff;
  logic illegal_ff;
  logic nxt_done;
  logic nxt_illegal;
  logic acked;
  logic [31:0] arith_result;
  logic arith_carry;
  logic arith_ovf;
  logic [31:0] arith_operand;
  logic [4:0] op;
  logic [1:0] tag;
  logic two_word;
  logic is_double;

  function automatic logic [15:0] sext_disp(input logic [15:0] w);
    sext_disp = {{8{w[exec_pkg::DISP_SIGN]}}, w[exec_pkg::DISP_HI:0]}; // [RULE2]
  endfunction

  function automatic logic [15:0] sel_reg(input logic [1:0] t, input logic [15:0] iv,
                                          input logic [15:0] r1, input logic [15:0] r2,
                                          input logic [15:0] r3);
    unique case (t)
      2'h0: sel_reg = iv;
      2'h1: sel_reg = r1;
      2'h2: sel_reg = r2;
      default: sel_reg = r3;
    endcase
  endfunction

  function automatic logic [15:0] sel_index(input logic [1:0] t, input logic [15:0] r1,
                                            input logic [15:0] r2, input logic [15:0] r3);
    sel_index = (t == exec_pkg::TAG_INSTR) ? exec_pkg::RST_WORD : sel_reg(t, 16'h0000, r1, r2, r3);
  endfunction

  // Pin input crossing for the permission switch
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sw_meta_ff <= 1'b0;
      sw_sync_ff <= 1'b0;
    end else begin
      sw_meta_ff <= protect_write_sw;
      sw_sync_ff <= sw_meta_ff;
    end
  end

  assign op = ir_ff[exec_pkg::OP_HI:exec_pkg::OP_LO];
  assign tag = ir_ff[exec_pkg::TAG_HI:exec_pkg::TAG_LO];
  assign two_word = ir_ff[exec_pkg::FMT_BIT];
  assign is_double = (op == exec_pkg::OP_DOUBLE_ADD);
  assign acked = mem_req_ff & mem_ack;
  assign arith_operand = is_double ? {hi_word_ff, mem_rdata} : {mem_rdata, 16'h0000};

  arith_unit u_arith (
    .acc_pair(({acc_ff, ext_ff})),
    .operand(arith_operand),
    .subtract((op == exec_pkg::OP_SUBTRACT)),
    .double_len(is_double),
    .result(arith_result),
    .carry_out(arith_carry),
    .overflow_out(arith_ovf)
  );

  // Latch the instruction and operand location
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ir_ff <= exec_pkg::RST_WORD;
      ea_ff <= exec_pkg::RST_WORD;
      hi_word_ff <= exec_pkg::RST_WORD;
    end else begin
      if (state_ff == S_IDLE && issue) begin
        ir_ff <= instr_word;
      end
      ea_ff <= nxt_ea;
      if (state_ff == S_OPND && acked) begin
        hi_word_ff <= mem_rdata;
      end
    end
  end

  // Sequencing and storage access requests
  always_comb begin
    nxt_state = state_ff;
    nxt_ea = ea_ff;
    nxt_addr = mem_addr_ff;
    nxt_wdata = mem_wdata_ff;
    nxt_we = 1'b0;
    nxt_prot_we = 1'b0;
    nxt_done = 1'b0;
    nxt_illegal = 1'b0;
    unique case (state_ff)
      S_IDLE: begin
        if (issue) begin
          if (instr_word[exec_pkg::OP_HI:exec_pkg::OP_LO] == exec_pkg::OP_LOAD_INDEX) begin
            // Load index holds the value itself, never indexed
            nxt_ea = instr_word[exec_pkg::FMT_BIT] ? addr_word : sext_disp(instr_word); // [RULE1] [RULE3]
          end else if (instr_word[exec_pkg::OP_HI:exec_pkg::OP_LO] == exec_pkg::OP_STORE_INDEX) begin
            nxt_ea = instr_word[exec_pkg::FMT_BIT] ? addr_word : i_ff + sext_disp(instr_word); // [RULE5]
          end else begin
            nxt_ea = instr_word[exec_pkg::FMT_BIT]
                   ? addr_word + sel_index(instr_word[exec_pkg::TAG_HI:exec_pkg::TAG_LO], xr1_ff, xr2_ff, xr3_ff)
                   : sel_reg(instr_word[exec_pkg::TAG_HI:exec_pkg::TAG_LO], i_ff, xr1_ff, xr2_ff, xr3_ff)
                     + sext_disp(instr_word); // [RULE9]
          end
          if (instr_word[exec_pkg::FMT_BIT] && instr_word[exec_pkg::IND_BIT]
              && instr_word[exec_pkg::OP_HI:exec_pkg::OP_LO] != exec_pkg::OP_LOAD_STATUS) begin
            nxt_state = S_IND;
            nxt_addr = nxt_ea;
          end else begin
            nxt_state = S_EXEC;
          end
        end
      end
      S_IND: begin
        if (acked) begin
          nxt_ea = mem_rdata; // [RULE4]
          nxt_state = S_EXEC;
        end
      end
      S_EXEC: begin
        nxt_addr = ea_ff;
        unique case (op)
          exec_pkg::OP_LOAD_INDEX: begin
            nxt_state = S_IDLE;
            nxt_done = 1'b1;
          end
          exec_pkg::OP_LOAD_STATUS: begin
            nxt_state = S_IDLE;
            nxt_done = 1'b1;
            nxt_illegal = two_word; // [RULE13]
          end
          exec_pkg::OP_STORE_INDEX: begin
            nxt_wdata = sel_reg(tag, i_ff, xr1_ff, xr2_ff, xr3_ff); // [RULE5]
            nxt_we = 1'b1;
            nxt_state = S_WRITE;
          end
          exec_pkg::OP_STORE_STATUS: begin
            if (two_word && ir_ff[exec_pkg::PROT_SEL_BIT]) begin // [RULE12]
              if (sw_sync_ff) begin // [RULE11]
                nxt_prot_we = 1'b1;
                nxt_state = S_PROT;
              end else begin
                nxt_state = S_IDLE;
                nxt_done = 1'b1;
              end
            end else begin
              nxt_state = S_OPND;
            end
          end
          exec_pkg::OP_ADD, exec_pkg::OP_SUBTRACT, exec_pkg::OP_DOUBLE_ADD: begin
            nxt_state = S_OPND;
          end
          default: begin
            nxt_state = S_IDLE;
            nxt_done = 1'b1;
            nxt_illegal = 1'b1;
          end
        endcase
      end
      S_OPND: begin
        if (acked) begin
          if (op == exec_pkg::OP_STORE_STATUS) begin
            // Merge indicators with the existing word
            nxt_wdata = {mem_rdata[exec_pkg::STS_KEEP_HI:exec_pkg::STS_KEEP_LO], 6'h00,
                         carry_ff, ovf_ff}; // [RULE6] [RULE7]
            nxt_we = 1'b1;
            nxt_state = S_WRITE;
          end else if (is_double) begin
            nxt_addr = ea_ff | exec_pkg::ODD_MASK; // [RULE19] [RULE20]
            nxt_state = S_OPND2;
          end else begin
            nxt_state = S_IDLE;
            nxt_done = 1'b1;
          end
        end
      end
      S_OPND2: begin
        if (acked) begin
          nxt_state = S_IDLE;
          nxt_done = 1'b1;
        end
      end
      S_WRITE: begin
        nxt_we = 1'b1;
        if (acked) begin
          nxt_we = 1'b0;
          nxt_state = S_IDLE;
          nxt_done = 1'b1;
        end
      end
      S_PROT: begin
        nxt_prot_we = 1'b1;
        if (acked) begin
          nxt_prot_we = 1'b0;
          nxt_state = S_IDLE;
          nxt_done = 1'b1;
        end
      end
      default: begin
        nxt_state = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= S_IDLE;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      illegal_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      busy_ff <= (nxt_state != S_IDLE);
      done_ff <= nxt_done;
      illegal_ff <= nxt_illegal;
    end
  end

  // Storage port: one idle cycle separates two accesses
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mem_req_ff <= 1'b0;
      mem_we_ff <= 1'b0;
      mem_prot_we_ff <= 1'b0;
      mem_addr_ff <= exec_pkg::RST_WORD;
      mem_wdata_ff <= exec_pkg::RST_WORD;
      mem_prot_wdata_ff <= 1'b0;
    end else begin
      mem_req_ff <= (nxt_state inside {S_IND, S_OPND, S_OPND2, S_WRITE, S_PROT}) && !acked;
      mem_we_ff <= nxt_we && !acked;
      mem_prot_we_ff <= nxt_prot_we && !acked;
      mem_addr_ff <= nxt_addr;
      mem_wdata_ff <= nxt_wdata;
      mem_prot_wdata_ff <= ir_ff[exec_pkg::PROT_VAL_BIT]; // [RULE10]
    end
  end

  // Instruction and index registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      i_ff <= exec_pkg::RST_WORD;
      xr1_ff <= exec_pkg::RST_WORD;
      xr2_ff <= exec_pkg::RST_WORD;
      xr3_ff <= exec_pkg::RST_WORD;
    end else if (state_ff == S_EXEC && op == exec_pkg::OP_LOAD_INDEX) begin
      unique case (tag)
        2'h0: i_ff <= ea_ff; // [RULE1] [RULE3] [RULE4]
        2'h1: xr1_ff <= ea_ff;
        2'h2: xr2_ff <= ea_ff;
        default: xr3_ff <= ea_ff;
      endcase
    end
  end

  // Accumulator and extension
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      acc_ff <= exec_pkg::RST_WORD;
      ext_ff <= exec_pkg::RST_WORD;
    end else if ((state_ff == S_OPND && acked && !is_double && op != exec_pkg::OP_STORE_STATUS)
                 || (state_ff == S_OPND2 && acked)) begin
      acc_ff <= arith_result[31:16]; // [RULE15] [RULE23]
      ext_ff <= arith_result[15:0]; // [RULE19]
    end
  end

  // Carry and overflow indicators
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      carry_ff <= exec_pkg::RST_IND;
      ovf_ff <= exec_pkg::RST_IND;
    end else if (state_ff == S_EXEC && op == exec_pkg::OP_LOAD_STATUS && !two_word) begin
      carry_ff <= ir_ff[exec_pkg::LDS_CARRY_BIT]; // [RULE13] [RULE14]
      ovf_ff <= ir_ff[exec_pkg::LDS_OVF_BIT];
    end else if (state_ff == S_OPND && acked && op == exec_pkg::OP_STORE_STATUS) begin
      carry_ff <= 1'b0; // [RULE8]
      ovf_ff <= 1'b0;
    end else if ((state_ff == S_OPND && acked && !is_double && op != exec_pkg::OP_STORE_STATUS)
                 || (state_ff == S_OPND2 && acked)) begin
      carry_ff <= arith_carry; // [RULE18] [RULE21] [RULE25]
      ovf_ff <= ovf_ff | arith_ovf; // [RULE16] [RULE17] [RULE22] [RULE24]
    end else if (overflow_test_clear) begin
      ovf_ff <= 1'b0; // [RULE17]
    end
  end

  assign busy = busy_ff;
  assign done = done_ff;
  assign illegal = illegal_ff;
  assign mem_req = mem_req_ff;
  assign mem_we = mem_we_ff;
  assign mem_prot_we = mem_prot_we_ff;
  assign mem_addr = mem_addr_ff;
  assign mem_wdata = mem_wdata_ff;
  assign mem_prot_wdata = mem_prot_wdata_ff;
  assign acc = acc_ff;
  assign acc_ext = ext_ff;
  assign carry = carry_ff;
  assign overflow = ovf_ff;
  assign instr_reg = i_ff;
  assign index_register1 = xr1_ff;
  assign index_register2 = xr2_ff;
  assign index_register3 = xr3_ff;
endmodule // index_status_add_execute

// >>> exec_properties.sv
// Port checker for the index, status and add execution block
`timescale 1ns/100ps
module exec_properties (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic issue,
  input wire logic [15:0] instr_word,
  input wire logic [15:0] addr_word,
  input wire logic protect_write_sw,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  input wire logic busy,
  input wire logic done,
  input wire logic illegal,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic mem_prot_we,
  input wire logic [15:0] mem_wdata,
  input wire logic mem_prot_wdata,
  input wire logic [15:0] acc,
  input wire logic [15:0] acc_ext,
  input wire logic carry,
  input wire logic overflow,
  input wire logic [15:0] instr_reg
);
  logic [15:0] cur_ff, adr_ff, acc0_ff, ext0_ff, rd_ff, rd0_ff;
  logic c0_ff, v0_ff, sub, ovf16, ovf32;
  logic [4:0] op;
  logic [16:0] s17;
  logic [32:0] s33;
  assign op = cur_ff[15:11];
  assign sub = op == exec_pkg::OP_SUBTRACT;
  assign s17 = sub ? {1'b0, acc0_ff} - {1'b0, rd_ff} : {1'b0, acc0_ff} + {1'b0, rd_ff};
  assign ovf16 = (acc0_ff[15] == (rd_ff[15] ^ sub)) && (s17[15] != acc0_ff[15]);
  assign s33 = {1'b0, acc0_ff, ext0_ff} + {1'b0, rd0_ff, rd_ff};
  assign ovf32 = (acc0_ff[15] == rd0_ff[15]) && (s33[31] != acc0_ff[15]);
  // Operands and indicator state seen when the instruction was taken
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      {cur_ff, adr_ff, acc0_ff, ext0_ff, c0_ff, v0_ff} <= '0;
    end else if (issue && !busy) begin
      {cur_ff, adr_ff, acc0_ff, ext0_ff, c0_ff, v0_ff} <= {instr_word, addr_word, acc, acc_ext, carry, overflow};
    end
  end
  // Last two words read from storage
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      {rd_ff, rd0_ff} <= '0;
    end else if (mem_req && mem_ack) begin
      {rd_ff, rd0_ff} <= {mem_rdata, rd_ff};
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  ldx_short_a: assert property (
    done && op == exec_pkg::OP_LOAD_INDEX && !cur_ff[10] && cur_ff[9:8] == 2'h0
    |-> instr_reg == {{8{cur_ff[7]}}, cur_ff[7:0]}) else $error("short load index value wrong");
  ldx_long_a: assert property (
    done && op == exec_pkg::OP_LOAD_INDEX && cur_ff[10] && cur_ff[9:8] == 2'h0
    |-> instr_reg == (cur_ff[7] ? rd_ff : adr_ff)) else $error("long load index value wrong");
  lds_load_a: assert property (
    issue && !busy && instr_word[15:10] == {exec_pkg::OP_LOAD_STATUS, 1'b0}
    |-> ##[1:3] (done && carry == cur_ff[1] && overflow == cur_ff[0])) else $error("load status wrong");
  sts_clear_a: assert property (
    done && !illegal && op == exec_pkg::OP_STORE_STATUS && !(cur_ff[10] && cur_ff[6])
    |-> !carry && !overflow) else $error("indicators not cleared");
  sts_merge_a: assert property (
    mem_req && mem_we && op == exec_pkg::OP_STORE_STATUS
    |-> mem_wdata == {rd_ff[15:8], 6'h00, c0_ff, v0_ff}) else $error("status word merge wrong");
  prot_write_a: assert property (
    mem_req && mem_prot_we |-> !mem_we && protect_write_sw && cur_ff[10] && cur_ff[6]
    && mem_prot_wdata == cur_ff[0]) else $error("protect bit write wrong");
  add_result_a: assert property (
    done && op == exec_pkg::OP_ADD
    |-> acc == s17[15:0] && carry == s17[16] && overflow == (v0_ff | ovf16)) else $error("add result wrong");
  sub_result_a: assert property (
    done && sub
    |-> acc == s17[15:0] && carry == s17[16] && overflow == (v0_ff | ovf16)) else $error("subtract result wrong");
  dadd_result_a: assert property (
    done && op == exec_pkg::OP_DOUBLE_ADD
    |-> {acc, acc_ext} == s33[31:0] && carry == s33[32] && overflow == (v0_ff | ovf32))
    else $error("double add result wrong");
  cover property (done && op == exec_pkg::OP_DOUBLE_ADD);
  cover property (mem_req && mem_prot_we);
  cover property (done && sub && overflow);
endmodule // exec_properties

bind index_status_add_execute exec_properties exec_properties_i (.clock, .rst_n, .issue, .instr_word,
  .addr_word, .protect_write_sw, .mem_ack, .mem_rdata, .busy, .done, .illegal, .mem_req, .mem_we,
  .mem_prot_we, .mem_wdata, .mem_prot_wdata, .acc, .acc_ext, .carry, .overflow, .instr_reg);

// >>> core_store_model.sv
// Core storage model answering after a set number of wait cycles
`timescale 1ns/100ps
module core_store_model (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic mem_prot_we,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic mem_prot_wdata,
  input wire logic [3:0] delay,
  output logic mem_ack,
  output logic [15:0] mem_rdata
);
  logic [15:0] word_mem [0:255];
  logic prot_mem [0:255];
  logic [3:0] wait_ff;
  // Read data toggles outside an answer so a stale value never looks valid
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mem_ack <= 1'b0;
      wait_ff <= 4'h0;
      mem_rdata <= 16'h5A5A;
    end else if (mem_req && !mem_ack && wait_ff == delay) begin
      mem_ack <= 1'b1;
      wait_ff <= 4'h0;
      mem_rdata <= word_mem[mem_addr[7:0]];
      if (mem_we) word_mem[mem_addr[7:0]] <= mem_wdata;
      if (mem_prot_we) prot_mem[mem_addr[7:0]] <= mem_prot_wdata;
    end else begin
      mem_ack <= 1'b0;
      wait_ff <= (mem_req && !mem_ack) ? wait_ff + 4'h1 : 4'h0;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule // core_store_model

// >>> testbench.sv
// Self-checking bench for the index, status and add execution block
`timescale 1ns/100ps
module testbench;
  logic clock = 1'b0;
  logic rst_n, issue, protect_write_sw, overflow_test_clear, mem_ack, busy, done, illegal;
  logic mem_req, mem_we, mem_prot_we, mem_prot_wdata, carry, overflow;
  logic [15:0] instr_word, addr_word, mem_rdata, mem_addr, mem_wdata, acc, acc_ext;
  logic [15:0] instr_reg, index_register1, index_register2, index_register3;
  logic [3:0] delay;
  int mismatches = 0;
  int total_checks = 0;
  always #5 clock = ~clock;
  index_status_add_execute index_status_add_execute_i (.clock, .rst_n, .issue, .instr_word, .addr_word,
    .protect_write_sw, .overflow_test_clear, .mem_ack, .mem_rdata, .busy, .done, .illegal, .mem_req,
    .mem_we, .mem_prot_we, .mem_addr, .mem_wdata, .mem_prot_wdata, .acc, .acc_ext, .carry, .overflow,
    .instr_reg, .index_register1, .index_register2, .index_register3);
  core_store_model core_store_model_i (.clock, .rst_n, .mem_req, .mem_we, .mem_prot_we, .mem_addr,
    .mem_wdata, .mem_prot_wdata, .delay, .mem_ack, .mem_rdata);
  task automatic complete_run();
    $display("mismatches %0d total_checks %0d", mismatches, total_checks);
    if (mismatches == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic [15:0] mw(input logic [7:0] a);
    return core_store_model_i.word_mem[a];
  endfunction
  task automatic poke(input logic [7:0] a, input logic [15:0] d);
    core_store_model_i.word_mem[a] = d;
  endtask
  // Issue one instruction and wait for its completion pulse
  task automatic run(input logic [15:0] iw, input logic [15:0] aw);
    int n;
    instr_word = iw;
    addr_word = aw;
    issue = 1'b1;
    @(posedge clock);
    #1 issue = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 60) begin
      @(posedge clock);
      #1 n++;
    end
    if (n == 60) begin
      mismatches++;
      complete_run();
    end
  endtask
  task automatic t_load_index();
    poke(8'h10, 16'hBEEF);
    run(16'h6085, 16'h0000); chk("instr_reg", 16'hFF85, instr_reg);
    run(16'h6107, 16'h0000); chk("index1", 16'h0007, index_register1);
    run(16'h6400, 16'h1234); chk("instr_reg", 16'h1234, instr_reg);
    run(16'h6780, 16'h0010); chk("index3", 16'hBEEF, index_register3);
  endtask
  task automatic t_store_index();
    poke(8'h11, 16'h0022);
    run(16'h6600, 16'h4321);
    run(16'h6C00, 16'h0020); chk("word 20", 16'h1234, mw(8'h20));
    run(16'h6E80, 16'h0011); chk("word 22", 16'h4321, mw(8'h22));
  endtask
  task automatic t_status();
    for (int k = 0; k < 4; k++) begin
      run(16'h2000 | k[15:0], 16'h0000);
      chk("carry", k[1], carry);
      chk("overflow", k[0], overflow);
    end
    poke(8'h30, 16'hA5FF);
    run(16'h2C00, 16'h0030); chk("word 30", 16'hA503, mw(8'h30));
    chk("indicators", 2'b00, {carry, overflow});
    run(16'h6000, 16'h0000);
    run(16'h2002, 16'h0000);
    poke(8'h31, 16'h7FFF);
    run(16'h2831, 16'h0000); chk("word 31", 16'h7F02, mw(8'h31));
    poke(8'h12, 16'h0032);
    poke(8'h32, 16'h0000);
    run(16'h2001, 16'h0000);
    run(16'h2C80, 16'h0012); chk("word 32", 16'h0001, mw(8'h32));
    run(16'h2001, 16'h0000);
    overflow_test_clear = 1'b1;
    @(posedge clock);
    #1 overflow_test_clear = 1'b0;
    chk("overflow", 1'b0, overflow);
  endtask
  task automatic t_protect();
    delay = 4'h3;
    protect_write_sw = 1'b1;
    poke(8'h40, 16'h1111);
    poke(8'h13, 16'h0040);
    repeat (3) @(posedge clock);
    #1;
    run(16'h2C41, 16'h0040); chk("protect 40", 1'b1, core_store_model_i.prot_mem[8'h40]);
    chk("word 40", 16'h1111, mw(8'h40));
    run(16'h2CC0, 16'h0013); chk("protect 40", 1'b0, core_store_model_i.prot_mem[8'h40]);
    protect_write_sw = 1'b0;
    repeat (3) @(posedge clock);
    #1;
    run(16'h2C41, 16'h0040); chk("protect 40", 1'b0, core_store_model_i.prot_mem[8'h40]);
  endtask
  task automatic t_arith();
    delay = 4'h0;
    poke(8'h50, 16'h7FFF);
    poke(8'h51, 16'h0001);
    poke(8'h52, 16'hFFFF);
    poke(8'h14, 16'h0052);
    poke(8'h53, 16'hFFFF);
    poke(8'h54, 16'h7FFE);
    poke(8'h55, 16'h8000);
    poke(8'h60, 16'h7FFF);
    poke(8'h61, 16'h0001);
    run(16'h2000, 16'h0000);
    run(16'h8400, 16'h0050); chk("acc", 16'h7FFF, acc);
    run(16'h8400, 16'h0051); chk("acc c v", 18'h2_0001, {acc, carry, overflow});
    run(16'h8480, 16'h0014); chk("acc c v", 18'h1_FFFF, {acc, carry, overflow});
    chk("word 52", 16'hFFFF, mw(8'h52));
    delay = 4'h2;
    run(16'h8400, 16'h0053); chk("acc c v", 18'h1_FFFB, {acc, carry, overflow});
    run(16'h9400, 16'h0054); chk("acc c v", 18'h0_0001, {acc, carry, overflow});
    chk("word 54", 16'h7FFE, mw(8'h54));
    run(16'h2000, 16'h0000);
    run(16'h9400, 16'h0055); chk("acc c v", 18'h2_0003, {acc, carry, overflow});
    run(16'h2002, 16'h0000);
    run(16'h8C00, 16'h0060); chk("acc ext", 32'hFFFF_0001, {acc, acc_ext});
    chk("c v", 2'b00, {carry, overflow});
    run(16'h8C00, 16'h0061); chk("acc ext", 32'h0000_0002, {acc, acc_ext});
    chk("c v", 2'b10, {carry, overflow});
  endtask
  initial begin
    rst_n = 1'b0;
    issue = 1'b0;
    instr_word = 16'h0000;
    addr_word = 16'h0000;
    protect_write_sw = 1'b0;
    overflow_test_clear = 1'b0;
    delay = 4'h1;
    repeat (3) @(posedge clock);
    #1 rst_n = 1'b1;
    t_load_index();
    t_store_index();
    t_status();
    t_protect();
    t_arith();
    complete_run();
  end
endmodule // testbench
